// ==== hw/spdrx_pkg.sv ====
package spdrx_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] RX_LOCK_STATUS_IDX = 16'hF600;
  localparam logic [15:0] RX_CONTROL_IDX = 16'hF601;
  localparam logic [15:0] RX_STREAM_DECODE_IDX = 16'hF602;
  localparam logic [31:0] RX_LOCK_STATUS_ADDR = {14'h0000, RX_LOCK_STATUS_IDX, 2'h0};
  localparam logic [31:0] RX_CONTROL_ADDR = {14'h0000, RX_CONTROL_IDX, 2'h0};
  localparam logic [31:0] RX_STREAM_DECODE_ADDR = {14'h0000, RX_STREAM_DECODE_IDX, 2'h0};

  localparam logic [15:0] RX_LOCK_STATUS_RST = 16'h0000;
  localparam logic [15:0] RX_CONTROL_RST = 16'h0000;
  localparam logic [15:0] RX_STREAM_DECODE_RST = 16'h0000;

  // field positions
  localparam int LOCK_BIT = 0;
  localparam int WL_SEL_LSB = 0;
  localparam int STRENGTH_BIT = 2;
  localparam int QUICK_BIT = 3;
  localparam int CTRL_W = 4;
  localparam int AUDIO_TYPE_BIT = 0;
  localparam int COMPR_BIT = 1;
  localparam int LEFT_WL_LSB = 2;
  localparam int RIGHT_WL_LSB = 6;

  // output word length select
  localparam logic [1:0] WL_SEL_24 = 2'h0;
  localparam logic [1:0] WL_SEL_20 = 2'h1;
  localparam logic [1:0] WL_SEL_16 = 2'h2;
  localparam logic [1:0] WL_SEL_AUTO = 2'h3;

  // lengths in bits
  localparam logic [4:0] LEN_NONE = 5'h00;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_17 = 5'h11;
  localparam logic [4:0] LEN_18 = 5'h12;
  localparam logic [4:0] LEN_19 = 5'h13;
  localparam logic [4:0] LEN_20 = 5'h14;
  localparam logic [4:0] LEN_21 = 5'h15;
  localparam logic [4:0] LEN_22 = 5'h16;
  localparam logic [4:0] LEN_23 = 5'h17;
  localparam logic [4:0] LEN_24 = 5'h18;

  // detected word length codes
  localparam logic [3:0] WLC_NONE = 4'h0;
  localparam logic [3:0] WLC_16 = 4'h2;
  localparam logic [3:0] WLC_17 = 4'hC;
  localparam logic [3:0] WLC_18 = 4'h4;
  localparam logic [3:0] WLC_19 = 4'h8;
  localparam logic [3:0] WLC_20 = 4'hA;
  localparam logic [3:0] WLC_21 = 4'hD;
  localparam logic [3:0] WLC_22 = 4'h5;
  localparam logic [3:0] WLC_23 = 4'h9;
  localparam logic [3:0] WLC_24 = 4'hB;
  localparam logic [3:0] WLC_20_OF_24 = 4'h3;

  // consecutive valid samples before lock
  localparam logic [6:0] LOCK_NORMAL_CNT = 7'h40;
  localparam logic [6:0] LOCK_QUICK_CNT = 7'h08;

  localparam int AUD_W = 24;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    REG_NONE,
    REG_LOCK,
    REG_CTRL,
    REG_DECODE
  } spdrx_reg_t;

  // one decoded subframe from the receiver front end
  typedef struct packed {
    logic smp_stb;
    logic smp_ok;
    logic smp_right;
    logic [AUD_W-1:0] smp_data;
    logic [3:0] cs_wl;
    logic audio_type;
    logic compression_format;
    logic fclk;
  } spdrx_rx_t;

  typedef struct packed {
    logic stb;
    logic right;
    logic [AUD_W-1:0] data;
    logic fclk;
  } spdrx_aud_t;

endpackage

// ==== hw/spdrx_wl_decode.sv ====
module spdrx_wl_decode
  import spdrx_pkg::*;
(
  input wire logic [3:0] cs_wl,
  output logic [3:0] code,
  output logic [4:0] len
);

  // unknown channel status codes report zero and no length
  always_comb begin
    code = cs_wl;
    case (cs_wl)
      WLC_16: len = LEN_16;
      WLC_17: len = LEN_17;
      WLC_18: len = LEN_18;
      WLC_19: len = LEN_19;
      WLC_20: len = LEN_20;
      WLC_21: len = LEN_21;
      WLC_22: len = LEN_22;
      WLC_23: len = LEN_23;
      WLC_24: len = LEN_24;
      WLC_20_OF_24: len = LEN_20;
      default: begin
        len = LEN_NONE;
        code = WLC_NONE;
      end
    endcase
  end

endmodule

// ==== hw/spdrx_word_trunc.sv ====
module spdrx_word_trunc #(
  parameter int W = 24
) (
  input wire logic [W-1:0] din,
  input wire logic [4:0] len,
  output logic [W-1:0] dout
);

  // msb aligned word; bits below the kept length are cleared, not rounded
  always_comb begin
    for (int i = 0; i < W; i++) begin
      dout[i] = (i >= (W - int'(len))) ? din[i] : 1'b0;
    end
  end

endmodule

// ==== hw/spdrx_status_ctrl.sv ====
// Behaviour
// - lock flag bit 0 shows current lock
// - lock after 64, or 8 quick, valid samples
// - strength bit 2 governs output on loss
// - strength 0: keep output going after loss
// - strength 1: stop output at loss at once
// - select 00/01/10 gives 24/20/16 bit words
// - select 11 takes length from channel status
// - right detected length code in bits 9:6
// - left detected length code in bits 5:2
// - codes for 16 to 20 bit maximum streams
// - codes for 20 to 24 bit maximum streams
// - compression format in decode bit 1
// - audio type in decode bit 0
module spdrx_status_ctrl
  import spdrx_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire spdrx_rx_t rx_in,
  output spdrx_aud_t aud_out,
  output logic rx_locked
);

  typedef struct packed {
    logic ap_valid;
    logic ap_write;
    spdrx_reg_t ap_reg;
    logic [31:0] rdata;
    logic [CTRL_W-1:0] ctrl;
    logic [6:0] run_cnt;
    logic locked;
    logic had_lock;
    logic [3:0] wl_left;
    logic [3:0] wl_right;
    logic audio_type;
    logic compression_format;
    spdrx_aud_t aud;
  } spdrx_state_t;

  spdrx_state_t state_q;
  spdrx_state_t state_d;

  logic [3:0] cs_code;
  logic [4:0] cs_len;
  logic [4:0] out_len;
  logic [AUD_W-1:0] trunc_data;
  logic take;
  spdrx_reg_t sel_reg;
  logic [6:0] lock_target;
  logic quick;
  logic strength;
  logic [1:0] wl_sel;
  logic out_en;
  logic [15:0] lock_word;
  logic [15:0] ctrl_word;
  logic [15:0] decode_word;

  // one decoder serves both channels; the sample says which it belongs to
  spdrx_wl_decode i_spdrx_wl_decode (
    .cs_wl(rx_in.cs_wl),
    .code(cs_code),
    .len(cs_len)
  );

  spdrx_word_trunc #(
    .W(AUD_W)
  ) i_spdrx_word_trunc (
    .din(rx_in.smp_data),
    .len(out_len),
    .dout(trunc_data)
  );

  // zero wait state slave, every answer OKAY
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = state_q.rdata;
  assign aud_out = state_q.aud;
  assign rx_locked = state_q.locked;

  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_comb begin
    sel_reg = REG_NONE;
    if (haddr == RX_LOCK_STATUS_ADDR) begin
      sel_reg = REG_LOCK;
    end else if (haddr == RX_CONTROL_ADDR) begin
      sel_reg = REG_CTRL;
    end else if (haddr == RX_STREAM_DECODE_ADDR) begin
      sel_reg = REG_DECODE;
    end
  end

  assign quick = state_q.ctrl[QUICK_BIT];
  assign strength = state_q.ctrl[STRENGTH_BIT];
  assign wl_sel = state_q.ctrl[WL_SEL_LSB +: 2];
  assign lock_target = quick ? LOCK_QUICK_CNT : LOCK_NORMAL_CNT;

  // weak strength cuts output with lock; strong coasts on once locked
  assign out_en = state_q.locked || (!strength && state_q.had_lock);

  always_comb begin
    case (wl_sel)
      WL_SEL_24: out_len = LEN_24;
      WL_SEL_20: out_len = LEN_20;
      WL_SEL_16: out_len = LEN_16;
      WL_SEL_AUTO: begin
        // unknown channel status falls back to the full word
        if (cs_len == LEN_NONE) begin
          out_len = LEN_24;
        end else begin
          out_len = cs_len;
        end
      end
      default: out_len = LEN_24;
    endcase
  end

  always_comb begin
    state_d = state_q;

    // data phase of a write: only the control register takes it
    if (state_q.ap_valid && state_q.ap_write && state_q.ap_reg == REG_CTRL) begin
      state_d.ctrl = hwdata[CTRL_W-1:0];
    end

    // lock tracking on every subframe
    if (rx_in.smp_stb) begin
      if (!rx_in.smp_ok) begin
        state_d.run_cnt = 7'h00;
        state_d.locked = 1'b0;
        if (strength) begin
          state_d.had_lock = 1'b0;
        end
      end else if (!state_q.locked) begin
        if (state_q.run_cnt + 7'h01 >= lock_target) begin
          state_d.locked = 1'b1;
          state_d.had_lock = 1'b1;
          state_d.run_cnt = 7'h00;
        end else begin
          state_d.run_cnt = state_q.run_cnt + 7'h01;
        end
      end
    end

    // channel status decode only from accepted samples
    if (rx_in.smp_stb && rx_in.smp_ok) begin
      if (rx_in.smp_right) begin
        state_d.wl_right = cs_code;
      end else begin
        state_d.wl_left = cs_code;
      end
      state_d.audio_type = rx_in.audio_type;
      state_d.compression_format = rx_in.compression_format;
    end

    // output side: weak mode stops in the very cycle of a bad sample
    state_d.aud.stb = 1'b0;
    if (rx_in.smp_stb && out_en && !(strength && !rx_in.smp_ok)) begin
      state_d.aud.stb = 1'b1;
      state_d.aud.right = rx_in.smp_right;
      state_d.aud.data = trunc_data;
    end
    if (!out_en || (strength && rx_in.smp_stb && !rx_in.smp_ok)) begin
      state_d.aud.fclk = 1'b0;
      if (strength) begin
        state_d.aud.data = '0;
      end
    end else begin
      state_d.aud.fclk = rx_in.fclk;
    end

    // address phase
    state_d.ap_valid = take;
    state_d.ap_write = take && hwrite;
    state_d.ap_reg = take ? sel_reg : REG_NONE;

    // the control read word uses the post-write value so a read right after a write sees it
    lock_word = RX_LOCK_STATUS_RST;
    lock_word[LOCK_BIT] = state_q.locked;
    ctrl_word = RX_CONTROL_RST;
    ctrl_word[CTRL_W-1:0] = state_d.ctrl;
    decode_word = RX_STREAM_DECODE_RST;
    decode_word[RIGHT_WL_LSB +: 4] = state_q.wl_right;
    decode_word[LEFT_WL_LSB +: 4] = state_q.wl_left;
    decode_word[COMPR_BIT] = state_q.compression_format;
    decode_word[AUDIO_TYPE_BIT] = state_q.audio_type;

    state_d.rdata = 32'h00000000;
    if (take && !hwrite) begin
      case (sel_reg)
        REG_LOCK: state_d.rdata = {16'h0000, lock_word};
        REG_CTRL: state_d.rdata = {16'h0000, ctrl_word};
        REG_DECODE: state_d.rdata = {16'h0000, decode_word};
        default: state_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// ==== dv/spdrx_status_ctrl_properties.sv ====
module spdrx_status_ctrl_properties
  import spdrx_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire spdrx_rx_t rx_in,
  input wire spdrx_aud_t aud_out,
  input wire logic rx_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wr_q, rc_q, rl_q, ru_q, act_q;
  logic [3:0] ctrl_q;
  logic [6:0] okc_q;
  wire ap = hsel && hready && htrans == HTRANS_NONSEQ;
  wire bad = rx_in.smp_stb && !rx_in.smp_ok;
  wire [6:0] need = ctrl_q[QUICK_BIT] ? LOCK_QUICK_CNT : LOCK_NORMAL_CNT;
  // shadow of the control word and of the output enable, built from the ports alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {wr_q, rc_q, rl_q, ru_q, act_q, ctrl_q, okc_q} <= '0;
    end else begin
      wr_q <= ap && hwrite && haddr == RX_CONTROL_ADDR;
      rc_q <= ap && !hwrite && haddr == RX_CONTROL_ADDR;
      rl_q <= ap && !hwrite && haddr == RX_LOCK_STATUS_ADDR;
      ru_q <= ap && !hwrite &&
        !(haddr inside {RX_LOCK_STATUS_ADDR, RX_CONTROL_ADDR, RX_STREAM_DECODE_ADDR});
      if (wr_q) ctrl_q <= hwdata[3:0];
      // saturate so a long locked run never wraps back onto the threshold
      if (rx_in.smp_stb) okc_q <= bad ? 7'h00 : okc_q + {6'h00, okc_q != 7'h7F};
      act_q <= (bad && ctrl_q[STRENGTH_BIT]) ? 1'b0 : (act_q || rx_locked);
    end
  end
  sequence bad_smp;
    bad;
  endsequence
  a_lock_drop: assert property (bad_smp |=> !rx_locked)
    else $error("lock held after bad sample");
  a_lock_count: assert property ($rose(rx_locked) |-> okc_q == need)
    else $error("lock at wrong sample count");
  a_weak_stop: assert property (bad_smp ##0 ctrl_q[STRENGTH_BIT] |=>
    !aud_out.stb && !aud_out.fclk && aud_out.data == '0) else $error("output not stopped");
  a_strong_keep: assert property (rx_in.smp_stb && act_q && !ctrl_q[STRENGTH_BIT]
    |=> aud_out.stb) else $error("sample not forwarded");
  a_fclk_follow: assert property (act_q && !ctrl_q[STRENGTH_BIT]
    |=> aud_out.fclk == $past(rx_in.fclk)) else $error("frame clock not following");
  a_ctrl_readback: assert property (rc_q |-> hrdata == {28'h0000000, ctrl_q})
    else $error("control readback wrong");
  // the word was built in the address phase, so it shows the flag of one cycle back
  a_lock_readback: assert property (rl_q |-> hrdata == {31'h00000000, $past(rx_locked)})
    else $error("lock readback wrong");
  a_unmapped_zero: assert property (ru_q |-> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

// ==== dv/spdrx_src_model.sv ====
module spdrx_src_model
  import spdrx_pkg::*;
(
  input wire logic clk,
  output spdrx_rx_t rx_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rx_in = '0;
  // fm is {audio type, compression format}; the frame clock toggles once per subframe
  task automatic send(input logic ok, input logic rt, input logic [3:0] cs, input logic [1:0] fm);
    @(posedge clk);
    rx_in <= {1'b1, ok, rt, 24'hFFFFFF, cs, fm, ~rx_in.fclk};
    @(posedge clk);
    rx_in.smp_stb <= 1'b0;
    // no sample stands between strobes, so the data lines must not look stable
    rx_in.smp_data <= ~rx_in.smp_data;
  endtask
endmodule

// ==== dv/spdrx_status_ctrl_tb_top.sv ====
module spdrx_status_ctrl_tb_top
  import spdrx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] WC [10] = '{4'h2, 4'hC, 4'h4, 4'h8, 4'hA, 4'hD, 4'h5, 4'h9, 4'hB, 4'h3};
  localparam logic [4:0] WL [10] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17,
    5'h18, 5'h14};
  localparam logic [4:0] SL [4] = '{5'h18, 5'h14, 5'h10, 5'h18};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd_smp;
  logic hreadyout, hresp, rx_locked;
  spdrx_rx_t rx_in;
  spdrx_aud_t aud_out;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  // captured at the edge itself, so read data never races the slave's update
  always @(posedge clk) rd_smp <= hrdata;
  spdrx_src_model i_spdrx_src_model(.clk(clk), .rx_in(rx_in));
  spdrx_status_ctrl i_spdrx_status_ctrl(.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .rx_in(rx_in), .aud_out(aud_out), .rx_locked(rx_locked));
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single transfer; a read is judged against exp, a write ignores it
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
    input logic [31:0] exp);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    #1;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    if (!wr) chk(rd_smp, exp);
  endtask
  task automatic smp(input logic ok, input logic rt, input logic [3:0] cs, input logic [1:0] fm);
    i_spdrx_src_model.send(ok, rt, cs, fm);
    #1;
  endtask
  task automatic t_regs();
    bus(1'b0, RX_CONTROL_ADDR, 32'h0, 32'h0);
    bus(1'b1, RX_CONTROL_ADDR, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, RX_LOCK_STATUS_ADDR, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, RX_STREAM_DECODE_ADDR, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 32'h00000100, 32'hFFFFFFFF, 32'h0);
    bus(1'b0, RX_CONTROL_ADDR, 32'h0, 32'h0000000F);
    bus(1'b0, RX_LOCK_STATUS_ADDR, 32'h0, 32'h0);
    bus(1'b0, RX_STREAM_DECODE_ADDR, 32'h0, 32'h0);
    bus(1'b0, 32'h00000100, 32'h0, 32'h0);
  endtask
  task automatic t_lock(input logic [3:0] c, input int n);
    bus(1'b1, RX_CONTROL_ADDR, {28'h0000000, c}, 32'h0);
    smp(1'b0, 1'b0, 4'h0, 2'h0);
    repeat (n - 1) smp(1'b1, 1'b0, 4'h0, 2'h0);
    chk({31'h0, rx_locked}, 32'h0);
    smp(1'b1, 1'b1, 4'h0, 2'h0);
    chk({31'h0, rx_locked}, 32'h1);
    // a first lock does not forward the sample that completes the count
    smp(1'b1, 1'b1, 4'h0, 2'h0);
    chk({6'h00, aud_out.stb, aud_out.right, aud_out.data},
      {8'h03, 24'hFFFFFF << (5'h18 - SL[c[1:0]])});
    bus(1'b0, RX_LOCK_STATUS_ADDR, 32'h0, 32'h1);
    smp(1'b0, 1'b0, 4'h0, 2'h0);
    chk({30'h0, rx_locked, aud_out.stb}, {31'h0, !c[2]});
  endtask
  task automatic t_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, RX_CONTROL_ADDR, 32'h0, 32'h0);
    bus(1'b0, RX_LOCK_STATUS_ADDR, 32'h0, 32'h0);
  endtask
  task automatic t_decode();
    logic [31:0] e;
    t_lock(4'hB, 8);
    for (int i = 0; i < 10; i++) begin
      smp(1'b1, 1'b0, WC[i], i[1:0]);
      smp(1'b1, 1'b0, WC[i], i[1:0]);
      chk({6'h00, aud_out.stb, aud_out.right, aud_out.data},
        {8'h02, 24'hFFFFFF << (5'h18 - WL[i])});
      smp(1'b1, 1'b1, WC[9 - i], i[1:0]);
      e = {22'h0, WC[9 - i], WC[i], i[0], i[1]};
      bus(1'b0, RX_STREAM_DECODE_ADDR, 32'h0, e);
    end
    smp(1'b1, 1'b0, 4'h7, 2'h0);
    smp(1'b1, 1'b1, 4'h1, 2'h0);
    bus(1'b0, RX_STREAM_DECODE_ADDR, 32'h0, 32'h0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    for (int s = 0; s < 4; s++) t_lock({1'b1, s[0], s[1:0]}, 8);
    t_lock(4'h0, 64);
    t_decode();
    t_reset();
    summarize();
  end
endmodule
bind spdrx_status_ctrl spdrx_status_ctrl_properties i_spdrx_status_ctrl_properties(.clk, .sys_rst,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .rx_in, .aud_out, .rx_locked);
